//--- pkg/fcw_pkg.sv
// ****************************************************************
// Constants of the flash register write and protect block
// ****************************************************************
package fcw_pkg;

    // Command opcodes, defaults that an integrator may change
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_WRITE_REGS = 8'h01;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_READ_CONFIG = 8'h15;
    localparam logic [7:0] OP_ENTER_ADDR32 = 8'hB7;
    localparam logic [7:0] OP_EXIT_ADDR32 = 8'hE9;
    localparam logic [7:0] OP_ENTER_QUAD_CMD = 8'h35;
    localparam logic [7:0] OP_EXIT_QUAD_CMD = 8'hF5;

    // Frame lengths in link clocks
    localparam logic [4:0] BITS_OPCODE = 5'h08;
    localparam logic [4:0] BITS_ONE_BYTE = 5'h10;
    localparam logic [4:0] BITS_TWO_BYTES = 5'h18;
    localparam logic [4:0] BITS_MAX = 5'h1F;

    // Status register fields
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 5;
    localparam int ST_QE = 6;
    localparam int ST_STATUS_WRITE_DISABLE = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Configuration register fields
    localparam int CF_DS_LO = 0;
    localparam int CF_DS_HI = 2;
    localparam int CF_TB = 3;
    localparam int CF_RSVD = 4;
    localparam int CF_A32 = 5;
    localparam int CF_DC_LO = 6;
    localparam int CF_DC_HI = 7;
    localparam logic [7:0] CONFIG_RESET = 8'h07;

    // Dummy clock counts per dummy_cycle_sel code
    localparam logic [3:0] DUMMY_4 = 4'h4;
    localparam logic [3:0] DUMMY_6 = 4'h6;
    localparam logic [3:0] DUMMY_8 = 4'h8;
    localparam logic [3:0] DUMMY_10 = 4'hA;

    // Self-timed register write cycle
    localparam int CLK_PERIOD_NS = 10;
    localparam int REG_WRITE_TIME_NS = 10000;
    localparam logic [9:0] REG_WRITE_CYCLES = 10'((REG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Number of protect blocks addressed by block_protect_level
    localparam logic [4:0] PROT_BLOCKS = 5'h10;

endpackage

//--- core/fcw_sync.sv
`timescale 1ns/100ps
// ****************************************************************
// Two flip-flop synchroniser for a level
// ****************************************************************
module fcw_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_r;
    logic meta_nxt;
    logic sync_nxt;

    // First stage feeds only the second stage
    always_comb begin
        meta_nxt = rst_i ? RESET_VAL : async_i;
        sync_nxt = rst_i ? RESET_VAL : meta_r;
    end

    always_ff @(posedge core_clk_i) begin
        meta_r <= meta_nxt;
        sync_o <= sync_nxt;
    end
endmodule

//--- core/fcw_core.sv
`timescale 1ns/100ps
// ****************************************************************
// Flash configuration register, register write and protection
// ****************************************************************
// Summary of operation
// - drive_strength_sel is volatile, resets to 111 (30 ohm), written only by register write
// - protect_from_bottom can only be set by register write and is cleared by reset, 0 protects top, 1 bottom
// - addr32_mode set by enter_addr32_cmd, cleared by exit command or reset
// - config byte: dummy 7:6, addr32 5, reserved 4, bottom 3, drive 2:0
// - fast, dual-out, quad-out reads use 8/6/8/10 dummy clocks
// - dual-I/O reads use 4/6/8/10, quad-I/O reads use 6/4/8/10 dummy clocks
// - register write executes only while write_enable_latch is set
// - register write leaves write_enable_latch and write_in_progress untouched by data
// - register write must end after exactly 8 or 16 data bits
// - valid write starts timed cycle; busy flag set, then busy and latch cleared
// - host may read status, including busy flag, during the write cycle
// - software protect mode allows latch setting and protect field rewriting
// - write disable set with protect pin low rejects every register write, except while quad_enable or quad command mode is set
// - hardware protect entered on disable bit and low pin, left on pin high
// - hardware protect disabled while quad command mode or quad_enable
// - program and erase refused inside the block protected region
// - status byte: disable 7, quad 6, protect level 5:2, latch 1, busy 0
// - quad_enable set disables the protect pin function
module fcw_core (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic chip_select_n_i,
    input wire logic serial_in_i,
    input wire logic write_protect_n_i,
    input wire logic pe_req_i,
    input wire logic [3:0] pe_block_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic [7:0] status_o,
    output logic [7:0] config_o,
    output logic hw_protect_mode_o,
    output logic quad_command_mode_o,
    output logic pe_refuse_o,
    output logic [3:0] fast_dummy_o,
    output logic [3:0] dual_io_dummy_o,
    output logic [3:0] quad_io_dummy_o
);
    // ************************************************************
    // Link domain: shift in frame, shift out a register
    // ************************************************************
    logic started_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [23:0] sh_r;
    logic [23:0] sh_nxt;
    logic [7:0] op_r;
    logic [7:0] op_nxt;
    logic [7:0] st_snap_r;
    logic [7:0] cf_snap_r;
    logic so_nxt;
    logic so_oe_nxt;
    logic [2:0] rd_idx;

    // Frame start flag, cleared while chip select is high
    always_ff @(posedge link_clk_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    // Bit counter, shifter and latched opcode
    always_comb begin
        cnt_nxt = started_r ? ((cnt_r == fcw_pkg::BITS_MAX) ? cnt_r : cnt_r + 5'h01) : 5'h01;
        sh_nxt = {sh_r[22:0], serial_in_i};
        op_nxt = (cnt_nxt == fcw_pkg::BITS_OPCODE) ? {sh_r[6:0], serial_in_i} : op_r;
    end

    always_ff @(posedge link_clk_i) begin
        cnt_r <= cnt_nxt;
        sh_r <= sh_nxt;
        op_r <= op_nxt;
    end

    // Read data, bit 7 first after the opcode, byte sent three times, then bit 0 held
    always_comb begin
        rd_idx = 3'h7 - cnt_r[2:0];
        so_oe_nxt = started_r && (cnt_r >= fcw_pkg::BITS_OPCODE)
                    && (op_r == fcw_pkg::OP_READ_STATUS || op_r == fcw_pkg::OP_READ_CONFIG);
        so_nxt = (op_r == fcw_pkg::OP_READ_STATUS) ? st_snap_r[rd_idx] : cf_snap_r[rd_idx];
    end

    always_ff @(negedge link_clk_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else begin
            serial_out_o <= so_nxt;
            serial_out_oe_o <= so_oe_nxt;
        end
    end

    // ************************************************************
    // Core domain: synchronisers and frame end detect
    // ************************************************************
    logic cs_s;
    logic wp_s;
    logic cs_d_r;
    logic frame_seen_r;
    logic frame_seen_nxt;
    logic frame_end;

    fcw_sync #(.RESET_VAL(1'b1)) u_cs_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(chip_select_n_i),
        .sync_o(cs_s)
    );

    fcw_sync #(.RESET_VAL(1'b1)) u_wp_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(write_protect_n_i),
        .sync_o(wp_s)
    );

    // Link registers are still by the time the rise is seen
    always_comb begin
        frame_end = cs_s && !cs_d_r && frame_seen_r;
        frame_seen_nxt = rst_i ? 1'b0 : (!cs_s ? 1'b1 : (frame_end ? 1'b0 : frame_seen_r));
    end

    always_ff @(posedge core_clk_i) begin
        cs_d_r <= rst_i ? 1'b1 : cs_s;
        frame_seen_r <= frame_seen_nxt;
    end

    // ************************************************************
    // Core domain: registers, commands and write cycle
    // ************************************************************
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] config_r;
    logic [7:0] config_nxt;
    logic qpi_r;
    logic qpi_nxt;
    logic [9:0] timer_r;
    logic [9:0] timer_nxt;
    logic hpm_now;
    logic op_only;
    logic wr_len_ok;
    logic wr_ok;
    logic [7:0] wr_st;
    logic [7:0] wr_cf;

    // Protection and write acceptance
    always_comb begin
        hpm_now = status_r[fcw_pkg::ST_STATUS_WRITE_DISABLE] && !wp_s && !status_r[fcw_pkg::ST_QE] && !qpi_r;
        op_only = frame_end && (cnt_r == fcw_pkg::BITS_OPCODE);
        wr_len_ok = (cnt_r == fcw_pkg::BITS_ONE_BYTE) || (cnt_r == fcw_pkg::BITS_TWO_BYTES);
        wr_ok = frame_end && (op_r == fcw_pkg::OP_WRITE_REGS) && wr_len_ok
                && status_r[fcw_pkg::ST_WEL] && !status_r[fcw_pkg::ST_WIP] && !hpm_now;
        wr_st = (cnt_r == fcw_pkg::BITS_TWO_BYTES) ? sh_r[15:8] : sh_r[7:0];
        wr_cf = sh_r[7:0];
    end

    // Next register values
    always_comb begin
        status_nxt = status_r;
        config_nxt = config_r;
        qpi_nxt = qpi_r;
        timer_nxt = timer_r;
        if (op_only && !status_r[fcw_pkg::ST_WIP]) begin
            case (op_r)
                fcw_pkg::OP_WRITE_ENABLE: status_nxt[fcw_pkg::ST_WEL] = 1'b1;
                fcw_pkg::OP_WRITE_DISABLE: status_nxt[fcw_pkg::ST_WEL] = 1'b0;
                fcw_pkg::OP_ENTER_ADDR32: config_nxt[fcw_pkg::CF_A32] = 1'b1;
                fcw_pkg::OP_EXIT_ADDR32: config_nxt[fcw_pkg::CF_A32] = 1'b0;
                fcw_pkg::OP_ENTER_QUAD_CMD: qpi_nxt = 1'b1;
                fcw_pkg::OP_EXIT_QUAD_CMD: qpi_nxt = 1'b0;
                default: qpi_nxt = qpi_r;
            endcase
        end
        if (wr_ok) begin
            // Data cannot touch latch or busy bits
            status_nxt[7:2] = wr_st[7:2];
            status_nxt[fcw_pkg::ST_WIP] = 1'b1;
            timer_nxt = fcw_pkg::REG_WRITE_CYCLES;
            if (cnt_r == fcw_pkg::BITS_TWO_BYTES) begin
                config_nxt[fcw_pkg::CF_DC_HI:fcw_pkg::CF_DC_LO] = wr_cf[fcw_pkg::CF_DC_HI:fcw_pkg::CF_DC_LO];
                config_nxt[fcw_pkg::CF_DS_HI:fcw_pkg::CF_DS_LO] = wr_cf[fcw_pkg::CF_DS_HI:fcw_pkg::CF_DS_LO];
                config_nxt[fcw_pkg::CF_TB] = config_r[fcw_pkg::CF_TB] | wr_cf[fcw_pkg::CF_TB];
            end
        end else if (status_r[fcw_pkg::ST_WIP]) begin
            timer_nxt = timer_r - 10'h001;
            if (timer_r == 10'h001) begin
                status_nxt[fcw_pkg::ST_WIP] = 1'b0;
                status_nxt[fcw_pkg::ST_WEL] = 1'b0;
            end
        end
        config_nxt[fcw_pkg::CF_RSVD] = 1'b0;
        if (rst_i) begin
            status_nxt = fcw_pkg::STATUS_RESET;
            config_nxt = fcw_pkg::CONFIG_RESET;
            qpi_nxt = 1'b0;
            timer_nxt = 10'h000;
        end
    end

    always_ff @(posedge core_clk_i) begin
        status_r <= status_nxt;
        config_r <= config_nxt;
        qpi_r <= qpi_nxt;
        timer_r <= timer_nxt;
    end

    // ************************************************************
    // Core domain: outputs and snapshots for the link
    // ************************************************************
    logic [3:0] fast_nxt;
    logic [3:0] dual_nxt;
    logic [3:0] quad_nxt;
    logic pe_hit;
    logic [4:0] blk;
    logic [4:0] lvl;

    // Dummy clocks and protected region decode
    always_comb begin
        case (config_r[fcw_pkg::CF_DC_HI:fcw_pkg::CF_DC_LO])
            2'h1: begin
                fast_nxt = fcw_pkg::DUMMY_6;
                dual_nxt = fcw_pkg::DUMMY_6;
                quad_nxt = fcw_pkg::DUMMY_4;
            end
            2'h2: begin
                fast_nxt = fcw_pkg::DUMMY_8;
                dual_nxt = fcw_pkg::DUMMY_8;
                quad_nxt = fcw_pkg::DUMMY_8;
            end
            2'h3: begin
                fast_nxt = fcw_pkg::DUMMY_10;
                dual_nxt = fcw_pkg::DUMMY_10;
                quad_nxt = fcw_pkg::DUMMY_10;
            end
            default: begin
                fast_nxt = fcw_pkg::DUMMY_8;
                dual_nxt = fcw_pkg::DUMMY_4;
                quad_nxt = fcw_pkg::DUMMY_6;
            end
        endcase
        blk = {1'b0, pe_block_i};
        lvl = {1'b0, status_r[fcw_pkg::ST_BP_HI:fcw_pkg::ST_BP_LO]};
        pe_hit = config_r[fcw_pkg::CF_TB] ? (blk < lvl) : (blk >= fcw_pkg::PROT_BLOCKS - lvl);
    end

    // Snapshots move only while chip select is high
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_snap_r <= fcw_pkg::STATUS_RESET;
            cf_snap_r <= fcw_pkg::CONFIG_RESET;
        end else if (cs_s) begin
            st_snap_r <= status_r;
            cf_snap_r <= config_r;
        end
    end

    // Registered outputs
    always_ff @(posedge core_clk_i) begin
        status_o <= rst_i ? fcw_pkg::STATUS_RESET : status_nxt;
        config_o <= rst_i ? fcw_pkg::CONFIG_RESET : config_nxt;
        hw_protect_mode_o <= !rst_i && hpm_now;
        quad_command_mode_o <= !rst_i && qpi_r;
        pe_refuse_o <= !rst_i && pe_req_i && pe_hit;
        fast_dummy_o <= rst_i ? fcw_pkg::DUMMY_8 : fast_nxt;
        dual_io_dummy_o <= rst_i ? fcw_pkg::DUMMY_4 : dual_nxt;
        quad_io_dummy_o <= rst_i ? fcw_pkg::DUMMY_6 : quad_nxt;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_wel_before_write;
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(status_r[fcw_pkg::ST_WIP]) |-> $past(status_r[fcw_pkg::ST_WEL]);
    endproperty
    a_wel_before_write: assert property (p_wel_before_write) else $error("write started without latch");

    property p_latch_kept;
        @(posedge core_clk_i) disable iff (rst_i)
        wr_ok |=> status_r[fcw_pkg::ST_WEL] && status_r[fcw_pkg::ST_WIP] && timer_r == fcw_pkg::REG_WRITE_CYCLES;
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("latch or busy wrong after write");

    property p_bad_length;
        @(posedge core_clk_i) disable iff (rst_i)
        frame_end && !wr_len_ok && !status_r[fcw_pkg::ST_WIP] |=> !status_r[fcw_pkg::ST_WIP];
    endproperty
    a_bad_length: assert property (p_bad_length) else $error("odd length write accepted");

    property p_cycle_end;
        @(posedge core_clk_i) disable iff (rst_i)
        $fell(status_r[fcw_pkg::ST_WIP]) |-> $past(timer_r) == 10'h001 && !status_r[fcw_pkg::ST_WEL];
    endproperty
    a_cycle_end: assert property (p_cycle_end) else $error("write cycle ended early or latch kept");

    property p_hw_reject;
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(status_r[fcw_pkg::ST_WIP]) |-> !$past(hpm_now);
    endproperty
    a_hw_reject: assert property (p_hw_reject) else $error("write accepted in hardware protect");

    property p_hw_mode;
        @(posedge core_clk_i) disable iff (rst_i)
        status_r[fcw_pkg::ST_STATUS_WRITE_DISABLE] && !wp_s && !status_r[fcw_pkg::ST_QE] && !qpi_r |=> hw_protect_mode_o;
    endproperty
    a_hw_mode: assert property (p_hw_mode) else $error("hardware protect not entered");

    property p_quad_off;
        @(posedge core_clk_i) disable iff (rst_i)
        status_r[fcw_pkg::ST_QE] || qpi_r |=> !hw_protect_mode_o;
    endproperty
    a_quad_off: assert property (p_quad_off) else $error("hardware protect while quad");

    property p_otp_bottom;
        @(posedge core_clk_i) disable iff (rst_i)
        config_r[fcw_pkg::CF_TB] |=> config_r[fcw_pkg::CF_TB];
    endproperty
    a_otp_bottom: assert property (p_otp_bottom) else $error("bottom protect bit cleared");

    property p_addr32;
        @(posedge core_clk_i) disable iff (rst_i)
        op_only && !status_r[fcw_pkg::ST_WIP] && op_r == fcw_pkg::OP_ENTER_ADDR32 ##1 1'b1
        |=> config_o[fcw_pkg::CF_A32];
    endproperty
    a_addr32: assert property (p_addr32) else $error("addr32 mode not set");

    property p_dummy;
        @(posedge core_clk_i) disable iff (rst_i)
        config_r[fcw_pkg::CF_DC_HI:fcw_pkg::CF_DC_LO] == 2'h1 |=> fast_dummy_o == fcw_pkg::DUMMY_6
        && quad_io_dummy_o == fcw_pkg::DUMMY_4;
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy count mismatch");
endmodule

//--- tb/fcw_host_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Host serial controller model
// ****************************************************************
module fcw_host_model (
    output logic link_clk_o,
    output logic chip_select_n_o,
    output logic serial_in_o,
    input wire logic serial_out_i,
    input wire logic serial_out_oe_i
);
    localparam int HALF_NS = 80;
    logic [7:0] read_byte_r;
    logic read_oe_ok_r;

    // Idle bus: clock stopped low, select released
    initial begin
        link_clk_o = 1'b0;
        chip_select_n_o = 1'b1;
        serial_in_o = 1'b0;
        read_byte_r = 8'h00;
        read_oe_ok_r = 1'b1;
    end

    // Frame of nbits taken from the top of data, then rd_bits clocks that capture serial_out
    task automatic frame(input logic [31:0] data, input int nbits, input int rd_bits);
        chip_select_n_o = 1'b0;
        read_oe_ok_r = 1'b1;
        for (int i = 0; i < nbits + rd_bits; i++) begin
            serial_in_o = (i < nbits) ? data[31 - i] : ~serial_in_o;
            #(HALF_NS);
            link_clk_o = 1'b1;
            if (i >= nbits) begin
                read_byte_r = {read_byte_r[6:0], serial_out_i};
                read_oe_ok_r = read_oe_ok_r & serial_out_oe_i;
            end
            #(HALF_NS);
            link_clk_o = 1'b0;
        end
        #(HALF_NS);
        chip_select_n_o = 1'b1;
        serial_in_o = ~serial_in_o; // Released line never shows the last bit
        #(4 * HALF_NS);
    endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
// ****************************************************************
// Testbench of the register write and protect block
// ****************************************************************
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic pe_req = 1'b0;
    logic [3:0] pe_block = 4'h0;
    logic link_clk, cs_n, sdi, sdo, sdo_oe, hw_prot, quad_mode, pe_refuse;
    logic [7:0] status, cfg;
    logic [3:0] fast_dc, dual_dc, quad_dc;
    int errors = 0;
    int check_count = 0;

    // Core clock
    always #5 core_clk = ~core_clk;

    fcw_host_model u_host (.link_clk_o(link_clk), .chip_select_n_o(cs_n), .serial_in_o(sdi),
        .serial_out_i(sdo), .serial_out_oe_i(sdo_oe));

    fcw_core u_dut (.core_clk_i(core_clk), .rst_i(rst), .link_clk_i(link_clk), .chip_select_n_i(cs_n),
        .serial_in_i(sdi), .write_protect_n_i(wp_n), .pe_req_i(pe_req), .pe_block_i(pe_block),
        .serial_out_o(sdo), .serial_out_oe_o(sdo_oe), .status_o(status), .config_o(cfg),
        .hw_protect_mode_o(hw_prot), .quad_command_mode_o(quad_mode), .pe_refuse_o(pe_refuse),
        .fast_dummy_o(fast_dc), .dual_io_dummy_o(dual_dc), .quad_io_dummy_o(quad_dc));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Single-byte command, then let the core act on it
    task automatic cmd(input logic [7:0] op);
        u_host.frame({op, 24'h000000}, 8, 0);
        repeat (10) @(posedge core_clk);
    endtask

    // Enable then register write; a good one is followed through its timed cycle
    task automatic wr_regs(input logic [7:0] st, input logic [7:0] cf, input int nbits, input bit ok);
        realtime t0;
        int i;
        cmd(fcw_pkg::OP_WRITE_ENABLE);
        u_host.frame({fcw_pkg::OP_WRITE_REGS, st, cf, 8'h00}, 8 + nbits, 0);
        t0 = $realtime - 320.0; // Chip select rose four half link periods before the frame returned
        repeat (6) @(posedge core_clk);
        if (ok) begin
            chk(status, {st[7:2], 2'b11}, "busy status");
            u_host.frame({fcw_pkg::OP_READ_STATUS, 24'h000000}, 8, 8);
            chk(u_host.read_byte_r, {st[7:2], 2'b11}, "polled status");
            chk({7'h00, u_host.read_oe_ok_r}, 8'h01, "read enable");
            for (i = 0; i < 1200 && status[0] !== 1'b0; i++) @(posedge core_clk);
            if (i == 1200) begin
                errors++;
                $display("mismatch at %0t: busy never ends", $time);
                print_verdict();
            end
            i = int'(($realtime - t0) / 10.0);
            chk({7'h00, i >= int'(fcw_pkg::REG_WRITE_CYCLES) && i <= int'(fcw_pkg::REG_WRITE_CYCLES) + 8},
                8'h01, "write time");
            chk(status, {st[7:2], 2'b00}, "status after write");
        end
    endtask

    // Program or erase request, refusal seen one cycle later
    task automatic pe_chk(input logic [3:0] blk, input logic exp);
        pe_req <= 1'b1;
        pe_block <= blk;
        @(posedge core_clk);
        pe_req <= 1'b0;
        #1;
        chk({7'h00, pe_refuse}, {7'h00, exp}, "refusal");
        @(posedge core_clk);
    endtask

    task automatic t_reset();
        chk(status, 8'h00, "status reset");
        chk(cfg, 8'h07, "config reset");
        chk({fast_dc, dual_dc}, {fcw_pkg::DUMMY_8, fcw_pkg::DUMMY_4}, "dummy reset");
        chk({4'h0, quad_dc}, {4'h0, fcw_pkg::DUMMY_6}, "quad dummy reset");
    endtask

    task automatic t_refused();
        u_host.frame({fcw_pkg::OP_WRITE_REGS, 16'hFC00, 8'h00}, 24, 0);
        repeat (10) @(posedge core_clk);
        chk(status, 8'h00, "no latch status");
        chk(cfg, 8'h07, "no latch config");
        wr_regs(8'h3C, 8'h00, 12, 1'b0);
        chk(status, 8'h02, "bad length status");
        chk(cfg, 8'h07, "bad length config");
        cmd(fcw_pkg::OP_WRITE_DISABLE);
        chk(status, 8'h00, "latch cleared");
    endtask

    // Every dummy code; address and reserved bits written high must stay low
    task automatic t_dummy();
        logic [3:0] f[4] = '{fcw_pkg::DUMMY_8, fcw_pkg::DUMMY_6, fcw_pkg::DUMMY_8, fcw_pkg::DUMMY_10};
        logic [3:0] d[4] = '{fcw_pkg::DUMMY_4, fcw_pkg::DUMMY_6, fcw_pkg::DUMMY_8, fcw_pkg::DUMMY_10};
        logic [3:0] q[4] = '{fcw_pkg::DUMMY_6, fcw_pkg::DUMMY_4, fcw_pkg::DUMMY_8, fcw_pkg::DUMMY_10};
        for (int c = 0; c < 4; c++) begin
            wr_regs(8'h03, {2'(c), 3'b110, 3'(c + 1)}, 16, 1'b1);
            chk(cfg, {2'(c), 3'b000, 3'(c + 1)}, "config write");
            chk({fast_dc, dual_dc}, {f[c], d[c]}, "dummy fast dual");
            chk({4'h0, quad_dc}, {4'h0, q[c]}, "dummy quad");
        end
    endtask

    task automatic t_protect();
        wr_regs(8'h08, 8'h00, 8, 1'b1);
        chk(cfg, 8'hC4, "byte write config");
        pe_chk(4'hF, 1'b1);
        pe_chk(4'hE, 1'b1);
        pe_chk(4'hD, 1'b0);
        wr_regs(8'h08, 8'h08, 16, 1'b1);
        chk(cfg, 8'h08, "bottom set");
        pe_chk(4'h1, 1'b1);
        pe_chk(4'h2, 1'b0);
        pe_chk(4'hF, 1'b0);
    endtask

    // Pin moved only while no write cycle runs
    task automatic t_hpm();
        wr_regs(8'h88, 8'h00, 8, 1'b1);
        wp_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk({7'h00, hw_prot}, 8'h01, "hw protect on");
        wr_regs(8'h00, 8'h00, 16, 1'b0);
        chk({status[7:2], 2'b00}, 8'h88, "hw protect write");
        chk(cfg, 8'h08, "hw protect config");
        cmd(fcw_pkg::OP_ENTER_QUAD_CMD);
        chk({6'h00, quad_mode, hw_prot}, 8'h02, "quad command blocks hw protect");
        cmd(fcw_pkg::OP_EXIT_QUAD_CMD);
        chk({6'h00, quad_mode, hw_prot}, 8'h01, "quad command left");
        wp_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk({7'h00, hw_prot}, 8'h00, "hw protect off");
        wr_regs(8'hC8, 8'h00, 8, 1'b1);
        wp_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk({7'h00, hw_prot}, 8'h00, "quad blocks hw protect");
        wr_regs(8'h04, 8'h00, 8, 1'b1);
        wp_n <= 1'b1;
    endtask

    task automatic t_addr32();
        cmd(fcw_pkg::OP_ENTER_ADDR32);
        chk(cfg, 8'h28, "addr32 set");
        u_host.frame({fcw_pkg::OP_READ_CONFIG, 24'h000000}, 8, 8);
        chk(u_host.read_byte_r, 8'h28, "config read");
        chk({7'h00, u_host.read_oe_ok_r}, 8'h01, "config read enable");
        cmd(fcw_pkg::OP_EXIT_ADDR32);
        chk(cfg, 8'h08, "addr32 clear");
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_reset();
        t_refused();
        t_dummy();
        t_protect();
        t_hpm();
        t_addr32();
        print_verdict();
    end
endmodule
